// >>> core/smi_pkg.sv
// Constants shared by both ends of the sector map detection link.
// Assumes a single 25 MHz clock domain with synchronous active-high reset.
package smi_pkg;

	// ==========================================================
	// Configuration bit positions
	localparam int ARCH_BIT      = 3;
	localparam int TOP_BIT       = 2;
	localparam int SIZE_BIT      = 1;
	localparam logic [7:0] CFG1_RST = 8'h00;
	localparam logic [7:0] CFG3_RST = 8'h00;

	// ==========================================================
	// Register locations seen by the read-any-register command
	localparam logic [31:0] ADDR_CFG1 = 32'h0000_0002;
	localparam logic [31:0] ADDR_CFG3 = 32'h0000_0004;
	localparam logic [7:0]  INSTR_RDAR = 8'h65;

	// ==========================================================
	// Detection descriptors: {address dword, command dword}
	localparam logic [7:0] MASK_ARCH = 8'h08;
	localparam logic [7:0] MASK_TOP  = 8'h04;
	localparam logic [1:0] ALEN_VAR  = 2'h3;
	localparam logic [3:0] LAT_VAR   = 4'hf;
	localparam logic [5:0] DESC_RSVD = 6'h3f;
	localparam logic [63:0] DESC0 = {ADDR_CFG3, MASK_ARCH, ALEN_VAR, 2'h3, LAT_VAR, INSTR_RDAR, DESC_RSVD, 2'h0};
	localparam logic [63:0] DESC1 = {ADDR_CFG1, MASK_TOP,  ALEN_VAR, 2'h3, LAT_VAR, INSTR_RDAR, DESC_RSVD, 2'h0};

	// ==========================================================
	// Supported index values
	localparam logic [2:0] IDX_BOT_64K  = 3'h0;
	localparam logic [2:0] IDX_BOT_256K = 3'h1;
	localparam logic [2:0] IDX_TOP_64K  = 3'h2;
	localparam logic [2:0] IDX_TOP_256K = 3'h3;
	localparam logic [2:0] IDX_UNI_64K  = 3'h4;
	localparam logic [2:0] IDX_UNI_256K = 3'h5;

	// ==========================================================
	// Controller registers on AHB-Lite, byte addresses
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_DATA   = 8'h08;
	localparam logic [3:0] LAT_RST    = 4'h8;
	localparam int CTRL_START = 0;
	localparam int CTRL_ADDR4 = 1;
	localparam int CTRL_LAT_LO = 4;
	localparam int CTRL_LAT_HI = 7;

endpackage : smi_pkg

// >>> core/smi_link_if.sv
// Link between the detection controller and the configuration decoder.
// Assumes both ends run on the same clock; the bench joins them.
`timescale 1ns/1ps
`default_nettype none

interface smi_link_if;
	logic        desc_sel;
	logic [63:0] desc_word;
	logic        req;
	logic [7:0]  instr;
	logic [31:0] addr;
	logic        addr4;
	logic [7:0]  rdata;
	logic        rvalid;

	modport dev  (input desc_sel, req, instr, addr, addr4, output desc_word, rdata, rvalid);
	modport host (output desc_sel, req, instr, addr, addr4, input desc_word, rdata, rvalid);
endinterface : smi_link_if

`default_nettype wire

// >>> core/smi_decoder.sv
// Device end: nonvolatile configuration holder, index decoder, descriptor table.
// Assumes the controller holds req steady until it has sampled the answer.
`timescale 1ns/1ps
`default_nettype none

module smi_decoder
(
	input  wire logic       i_clk,
	input  wire logic       i_srst,
	input  wire logic [7:0] i_nv_cfg1,
	input  wire logic [7:0] i_nv_cfg3,
	input  wire logic       i_nv_wr,
	input  wire logic [3:0] i_latency,
	output logic      [2:0] o_cfg_index,
	output logic            o_hybrid,
	output logic            o_param_top,
	output logic            o_sector_256k,
	output logic            o_invalid_map,
	smi_link_if.dev         link
);

	typedef struct packed {
		logic        loaded;
		logic [7:0]  cfg1;
		logic [7:0]  cfg3;
		logic [2:0]  idx;
		logic        hybrid;
		logic        top;
		logic        big;
		logic        invalid;
		logic [4:0]  cnt;
		logic [7:0]  rdata;
		logic        rvalid;
		logic [63:0] desc;
	} smi_dec_s;

	smi_dec_s st_r;
	smi_dec_s st_nxt;
	logic [2:0] idx_w;
	logic [4:0] need_w;

	// ==========================================================
	// Decode and link answer
	always_comb
	begin
		st_nxt = st_r;
		// Storage is captured after reset release and on each rewrite
		if (!st_r.loaded || i_nv_wr)
		begin
			st_nxt.loaded = 1'b1;
			st_nxt.cfg1   = i_nv_cfg1;
			st_nxt.cfg3   = i_nv_cfg3;
		end
		idx_w = {st_r.cfg3[smi_pkg::ARCH_BIT], st_r.cfg1[smi_pkg::TOP_BIT],
			st_r.cfg3[smi_pkg::SIZE_BIT]};
		st_nxt.idx     = idx_w;
		st_nxt.hybrid  = !idx_w[2];
		st_nxt.top     = !idx_w[2] && idx_w[1];
		st_nxt.big     = idx_w[0];
		// Top bit set in uniform mode has no listed map, so o_invalid_map is raised; o_hybrid low and o_sector_256k still show uniform and size
		st_nxt.invalid = !(idx_w inside {smi_pkg::IDX_BOT_64K, smi_pkg::IDX_BOT_256K, smi_pkg::IDX_TOP_64K,
			smi_pkg::IDX_TOP_256K, smi_pkg::IDX_UNI_64K, smi_pkg::IDX_UNI_256K});
		st_nxt.desc = link.desc_sel ? smi_pkg::DESC1 : smi_pkg::DESC0;
		need_w = (link.addr4 ? 5'h04 : 5'h03) + {1'b0, i_latency};
		if (!link.req)
		begin
			st_nxt.cnt    = '0;
			st_nxt.rvalid = 1'b0;
			st_nxt.rdata  = '0;
		end
		else if (st_r.cnt != need_w)
			st_nxt.cnt = st_r.cnt + 5'h01;
		else if (!st_r.rvalid)
		begin
			st_nxt.rvalid = 1'b1;
			if (link.instr != smi_pkg::INSTR_RDAR)
				st_nxt.rdata = '0;
			else if (link.addr == smi_pkg::ADDR_CFG3)
				st_nxt.rdata = st_r.cfg3;
			else if (link.addr == smi_pkg::ADDR_CFG1)
				st_nxt.rdata = st_r.cfg1;
			else
				st_nxt.rdata = '0;
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (i_srst)
		begin
			st_r        <= '0;
			st_r.cfg1   <= smi_pkg::CFG1_RST;
			st_r.cfg3   <= smi_pkg::CFG3_RST;
			st_r.hybrid <= 1'b1;
			st_r.desc   <= smi_pkg::DESC0;
		end
		else
			st_r <= st_nxt;
	end

	assign o_cfg_index    = st_r.idx;
	assign o_hybrid       = st_r.hybrid;
	assign o_param_top    = st_r.top;
	assign o_sector_256k  = st_r.big;
	assign o_invalid_map  = st_r.invalid;
	assign link.desc_word = st_r.desc;
	assign link.rdata     = st_r.rdata;
	assign link.rvalid    = st_r.rvalid;

endmodule : smi_decoder

`default_nettype wire

// >>> core/smi_host.sv
// Host end: walks the two detection descriptors and reads the selected bits.
// Orders and status reach it over AHB-Lite; the device end sits on the link.
// How it works
// - Index is arch, location, size, MSB first
// - Arch bit 0 hybrid, 1 uniform
// - Location bit puts 4 KB sectors bottom/top
// - Size bit picks 64 KB or 256 KB
// - Indices 00h to 05h decode to six layouts
// - Location bit ignored in uniform layout; here it gives index 06h/07h and raises o_invalid_map
// - Host programs only supported bit combinations; the bench also programs indices 06h and 07h
// - Detection uses read-any-register instruction 65h
// - Length field 11b means configured address length
// - Latency field 1111b means configured dummy latency
// - Mask 08h extracts bit 3, architecture
// - Descriptor bits 1:0 zero, 7:2 ones
// - First command reads address 04h
// - Mask 04h extracts bit 2, location
// - Second command reads address 02h
//
// Decided for this implementation: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module smi_host
(
	input  wire logic        i_clk,
	input  wire logic        i_srst,
	input  wire logic        i_hsel,
	input  wire logic [31:0] i_haddr,
	input  wire logic [1:0]  i_htrans,
	input  wire logic        i_hwrite,
	input  wire logic [2:0]  i_hsize,
	input  wire logic [31:0] i_hwdata,
	input  wire logic        i_hready,
	output logic      [31:0] o_hrdata,
	output logic             o_hreadyout,
	output logic             o_hresp,
	output logic             o_busy,
	smi_link_if.host         link
);

	typedef enum logic [2:0] {
		SMI_IDLE,
		SMI_DESC,
		SMI_CHECK,
		SMI_CMD,
		SMI_WAIT
	} smi_state_e;

	typedef struct packed {
		smi_state_e  state;
		logic        step;
		logic        addr4;
		logic [3:0]  lat;
		logic        done;
		logic        err;
		logic        arch;
		logic        top;
		logic [7:0]  byte0;
		logic [7:0]  byte1;
		logic [63:0] desc;
		logic [4:0]  cnt;
		logic [4:0]  need;
		logic        req;
		logic [7:0]  instr;
		logic [31:0] addr;
		logic        cmd_addr4;
		logic        wr_pend;
		logic [7:0]  wr_addr;
		logic [31:0] hrdata;
	} smi_host_s;

	smi_host_s st_r;
	smi_host_s st_nxt;
	logic       addr_phase;
	logic       start_w;
	logic       bit_w;
	logic [3:0] lat_w;

	// ==========================================================
	// Bus slave: zero wait states, read data loaded in the address phase
	always_comb
	begin
		st_nxt     = st_r;
		start_w    = 1'b0;
		addr_phase = i_hsel && i_htrans[1] && i_hready;
		st_nxt.wr_pend = addr_phase && i_hwrite;
		if (addr_phase)
			st_nxt.wr_addr = i_haddr[7:0];
		if (st_r.wr_pend && st_r.wr_addr == smi_pkg::REG_CTRL)
		begin
			st_nxt.addr4 = i_hwdata[smi_pkg::CTRL_ADDR4];
			st_nxt.lat   = i_hwdata[smi_pkg::CTRL_LAT_HI:smi_pkg::CTRL_LAT_LO];
			start_w      = i_hwdata[smi_pkg::CTRL_START];
		end
		if (addr_phase && !i_hwrite)
		begin
			if (i_haddr[7:0] == smi_pkg::REG_CTRL)
				st_nxt.hrdata = {24'h000000, st_r.lat, 2'h0, st_r.addr4, 1'b0};
			else if (i_haddr[7:0] == smi_pkg::REG_STATUS)
				st_nxt.hrdata = {27'h0000000, st_r.top, st_r.arch, st_r.err, st_r.done,
					st_r.state != SMI_IDLE};
			else if (i_haddr[7:0] == smi_pkg::REG_DATA)
				st_nxt.hrdata = {16'h0000, st_r.byte1, st_r.byte0};
			else
				st_nxt.hrdata = '0;
		end

		// ==========================================================
		// Detection sequence
		bit_w = |(link.rdata & st_r.desc[31:24]);
		lat_w = (st_r.desc[19:16] == smi_pkg::LAT_VAR) ? st_r.lat : st_r.desc[19:16];
		case (st_r.state)
			SMI_IDLE:
			begin
				// A start while busy is ignored; the running walk finishes first
				if (start_w)
				begin
					st_nxt.state = SMI_DESC;
					st_nxt.step  = 1'b0;
					st_nxt.done  = 1'b0;
					st_nxt.err   = 1'b0;
				end
			end
			SMI_DESC:
				// Device registers the descriptor one cycle after the select
				st_nxt.state = SMI_CHECK;
			SMI_CHECK:
			begin
				st_nxt.desc = link.desc_word;
				st_nxt.state = SMI_CMD;
			end
			SMI_CMD:
			begin
				if (st_r.desc[1:0] != 2'h0 || st_r.desc[7:2] != smi_pkg::DESC_RSVD)
				begin
					st_nxt.err   = 1'b1;
					st_nxt.done  = 1'b1;
					st_nxt.state = SMI_IDLE;
				end
				else
				begin
					st_nxt.instr = st_r.desc[15:8];
					st_nxt.addr  = st_r.desc[63:32];
					st_nxt.cmd_addr4 = (st_r.desc[23:22] == smi_pkg::ALEN_VAR) ? st_r.addr4
						: st_r.desc[22];
					st_nxt.need  = (st_nxt.cmd_addr4 ? 5'h04 : 5'h03) + {1'b0, lat_w};
					st_nxt.cnt   = '0;
					st_nxt.req   = 1'b1;
					st_nxt.state = SMI_WAIT;
				end
			end
			SMI_WAIT:
			begin
				// Sample only once our own latency count has run out
				if (st_r.cnt != st_r.need + 5'h01)
					st_nxt.cnt = st_r.cnt + 5'h01;
				else
				begin
					st_nxt.req = 1'b0;
					if (!link.rvalid)
						st_nxt.err = 1'b1;
					if (!st_r.step)
					begin
						st_nxt.byte0 = link.rdata;
						st_nxt.arch  = bit_w;
						st_nxt.step  = 1'b1;
						st_nxt.state = SMI_DESC;
					end
					else
					begin
						st_nxt.byte1 = link.rdata;
						st_nxt.top   = bit_w;
						st_nxt.done  = 1'b1;
						st_nxt.state = SMI_IDLE;
					end
				end
			end
			default:
				st_nxt.state = SMI_IDLE;
		endcase
	end

	always_ff @(posedge i_clk)
	begin
		if (i_srst)
		begin
			st_r       <= '0;
			st_r.state <= SMI_IDLE;
			st_r.lat   <= smi_pkg::LAT_RST;
		end
		else
			st_r <= st_nxt;
	end

	// ==========================================================
	// Outputs
	assign o_hrdata      = st_r.hrdata;
	assign o_hreadyout   = 1'b1;
	assign o_hresp       = 1'b0;
	assign o_busy        = st_r.state != SMI_IDLE;
	assign link.desc_sel = st_r.step;
	assign link.req      = st_r.req;
	assign link.instr    = st_r.instr;
	assign link.addr     = st_r.addr;
	assign link.addr4    = st_r.cmd_addr4;

endmodule : smi_host

`default_nettype wire

// >>> verification/smi_sva.sv
// Checker for the link that joins the host end to the decoder end.
// Assumes one clock; the bench instantiates it beside the link.
`timescale 1ns/1ps
`default_nettype none

module smi_sva
(
	input wire logic        i_clk,
	input wire logic        i_srst,
	input wire logic        i_desc_sel,
	input wire logic [63:0] i_desc_word,
	input wire logic        i_req,
	input wire logic [7:0]  i_instr,
	input wire logic [31:0] i_addr,
	input wire logic        i_addr4,
	input wire logic [7:0]  i_rdata,
	input wire logic        i_rvalid
);
	// ==========================================================
	// Link properties
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_srst);

	property p_instr; i_req |-> i_instr == smi_pkg::INSTR_RDAR; endproperty
	a_instr: assert property (p_instr) else $error("bad command code");
	property p_addr; i_req |-> i_addr == (i_desc_sel ? smi_pkg::ADDR_CFG1 : smi_pkg::ADDR_CFG3); endproperty
	a_addr: assert property (p_addr) else $error("bad command address");
	property p_low; i_desc_word[7:0] == 8'hfc; endproperty
	a_low: assert property (p_low) else $error("bad descriptor low byte");
	property p_mid; i_desc_word[23:8] == 16'hff65; endproperty
	a_mid: assert property (p_mid) else $error("bad length, latency or code");
	property p_mask;
		i_desc_word[63:32] == smi_pkg::ADDR_CFG3 ? i_desc_word[31:24] == 8'h08
			: i_desc_word[63:32] == smi_pkg::ADDR_CFG1 && i_desc_word[31:24] == 8'h04;
	endproperty
	a_mask: assert property (p_mask) else $error("mask does not suit address");
	// A command that shifts mid-wait would read the wrong register
	property p_hold; i_req ##1 i_req |-> $stable(i_addr) && $stable(i_instr) && $stable(i_addr4); endproperty
	a_hold: assert property (p_hold) else $error("command changed while pending");
	property p_rv; i_rvalid && i_req ##1 i_req |-> i_rvalid && $stable(i_rdata); endproperty
	a_rv: assert property (p_rv) else $error("answer dropped while requested");
	property p_clr; !i_req ##1 !i_req |-> !i_rvalid; endproperty
	a_clr: assert property (p_clr) else $error("answer without request");
endmodule : smi_sva

`default_nettype wire

// >>> verification/tb_top.sv
// Bench joining host and decoder ends; random configuration, AHB-Lite orders.
// Assumes the design files compile first.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
	logic        i_clk = 1'b0;
	logic        i_srst = 1'b1;
	logic        hsel = 1'b0;
	logic        hwrite = 1'b0;
	logic        nv_wr = 1'b0;
	logic [1:0]  htrans = 2'h0;
	logic [2:0]  hsize = 3'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic [31:0] rd;
	logic [7:0]  cfg1 = 8'h00;
	logic [7:0]  cfg3 = 8'h00;
	logic [3:0]  lat = 4'h8;
	logic        hrdy, hresp, busy, hyb, top, s256, inv;
	logic [2:0]  idx;
	int          err_total = 0;
	int          n_compared = 0;
	int          seed = 48781;
	int          i, j, k;

	smi_link_if link ();
	always #20 i_clk = ~i_clk;

	smi_host u_smi_host (.i_clk(i_clk), .i_srst(i_srst), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
		.i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hrdy), .o_hrdata(hrdata),
		.o_hreadyout(hrdy), .o_hresp(hresp), .o_busy(busy), .link(link));
	smi_decoder u_smi_decoder (.i_clk(i_clk), .i_srst(i_srst), .i_nv_cfg1(cfg1), .i_nv_cfg3(cfg3),
		.i_nv_wr(nv_wr), .i_latency(lat), .o_cfg_index(idx), .o_hybrid(hyb), .o_param_top(top),
		.o_sector_256k(s256), .o_invalid_map(inv), .link(link));
	smi_sva u_smi_sva (.i_clk(i_clk), .i_srst(i_srst), .i_desc_sel(link.desc_sel), .i_desc_word(link.desc_word),
		.i_req(link.req), .i_instr(link.instr), .i_addr(link.addr), .i_addr4(link.addr4), .i_rdata(link.rdata),
		.i_rvalid(link.rvalid));

	// ==========================================================
	// Shared tasks
	task final_report;
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : final_report

	task check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			$display("mismatch at %0t seen %h expected %h", $time, seen, exp);
			err_total++;
		end
	endtask : check

	task wait_rdy;
		@(posedge i_clk);
		for (k = 0; k < 50 && hrdy !== 1'b1; k++)
			@(posedge i_clk);
		if (hrdy !== 1'b1)
		begin
			err_total++;
			final_report();
		end
	endtask : wait_rdy

	task ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		@(posedge i_clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hsize <= 3'h2;
		hwrite <= wr;
		wait_rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		wait_rdy();
		rd = hrdata;
	endtask : ahb

	// Start a walk and poll status until it ends; status is left in rd
	task walk(input logic [3:0] l);
		ahb(1'b1, smi_pkg::REG_CTRL, {24'h0, l, 2'h0, 1'($random(seed)), 1'b1});
		rd = 32'h1;
		for (j = 0; j < 100 && rd[0] !== 1'b0; j++)
			ahb(1'b0, smi_pkg::REG_STATUS, 32'h0);
		if (rd[0] !== 1'b0)
		begin
			err_total++;
			final_report();
		end
	endtask : walk

	// ==========================================================
	// Main sequence
	initial
	begin
		repeat (10) @(posedge i_clk);
		i_srst <= 1'b0;
		for (i = 0; i < 8; i++)
		begin
			@(posedge i_clk);
			cfg3 <= 8'($random(seed)) & 8'hf5 | {4'h0, i[2], 1'b0, i[0], 1'b0};
			cfg1 <= 8'($random(seed)) & 8'hfb | {5'h0, i[1], 2'h0};
			nv_wr <= 1'b1;
			lat <= 4'($random(seed));
			@(posedge i_clk);
			nv_wr <= 1'b0;
			repeat (3) @(posedge i_clk);
			check({29'h0, idx}, i);
			check({31'h0, inv}, i > 5);
			if (i < 6)
				check({29'h0, hyb, top, s256}, {!i[2], !i[2] & i[1], i[0]});
			cfg3 <= ~cfg3;
			cfg1 <= ~cfg1;
			repeat (3) @(posedge i_clk);
			check({29'h0, idx}, i);
			walk(lat);
			check(rd[4:0], {i[1], i[2], 3'b010});
			check({30'h0, hresp, busy}, 32'h0);
			ahb(1'b0, smi_pkg::REG_DATA, 32'h0);
			check({rd[10], rd[3]}, {i[1], i[2]});
			$display("test index %0d done", i);
		end
		// Host latency one short samples before the answer, so both commands flag an error
		@(posedge i_clk);
		lat <= 4'h6;
		walk(4'h5);
		check(rd[2:0], 3'b110);
		ahb(1'b0, 8'h0c, 32'h0);
		check(rd, 32'h0);
		$display("test latency and unmapped done");
		final_report();
	end
endmodule : tb_top

`default_nettype wire
